// *** acc_map.svh ***
/*
 * register map of the channel control bank: indices, field positions,
 * reset values and fixed pattern constants.
 * assumes inclusion by acc_pkg.sv and the modules; definitions only.
 */
// What this block does
// - channel A dither active at 00, off at 11 with secondary bits set.
// - channel B dither active at 00, off at 11 with secondary bits set.
// - channel A digital gain applied only while its gain bit is 1.
// - channel B digital gain applied only while its gain bit is 1.
// - test pattern enable puts selected patterns on outputs, else data.
// - soft reset bit restores all registers to defaults, self clears.
// - fast overrange select picks fast or normal overrange on pins.
// - alignment bit runs both pattern generators in step.
// - format bit: 0 two's complement, 1 offset binary.
// - pattern select codes choose normal, zeros, ones, ramp and others.
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define ACC_IDX_DITHER 11'h001
`define ACC_IDX_GAIN_A 11'h003
`define ACC_IDX_GAIN_B 11'h004
`define ACC_IDX_PAT_RST 11'h006
`define ACC_IDX_MODE_A 11'h007
`define ACC_IDX_MODE_B 11'h008
`define ACC_IDX_FORMAT 11'h009
`define ACC_IDX_PSEL_A 11'h00a
`define ACC_IDX_PSEL_B 11'h00b
`define ACC_IDX_DAUX_A 11'h434
`define ACC_IDX_DAUX_B 11'h534

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ACC_F_DITH_A 5:4
`define ACC_F_DITH_B 3:2
`define ACC_F_GAIN 1
`define ACC_F_TP_EN 1
`define ACC_F_SRST 0
`define ACC_F_HARM 4:2
`define ACC_F_FAST_OVR 1
`define ACC_F_ALIGN 1
`define ACC_F_FMT 0
`define ACC_F_PSEL_A 3:0
`define ACC_F_PSEL_B 7:4
`define ACC_F_DAUX_HI 5
`define ACC_F_DAUX_LO 3

// ----------------------------------------------------------------
// reset values and constants
// ----------------------------------------------------------------
`define ACC_RST_BYTE 8'h00
`define ACC_DITH_OFF 2'h3
`define ACC_SIGN_BIT 14'h2000
`define ACC_POS_MAX 14'h1fff
`define ACC_DESKEW 14'h3aaa
`define ACC_TOGGLE 14'h2aaa
`define ACC_LFSR_SEED 14'h0001

`endif

// *** acc_pkg.sv ***
/*
 * types shared by the channel control bank.
 * assumes acc_map.svh on the include path.
 */
`include "acc_map.svh"
package acc_pkg;
	typedef logic [13:0] acc_sample_t;
	typedef logic [7:0] acc_byte_t;
	typedef enum logic [3:0] {
		ACC_PAT_NORMAL = 4'h0,
		ACC_PAT_ZEROS = 4'h1,
		ACC_PAT_ONES = 4'h2,
		ACC_PAT_TOGGLE = 4'h3,
		ACC_PAT_RAMP = 4'h4,
		ACC_PAT_CUSTOM = 4'h5,
		ACC_PAT_DESKEW = 4'h6,
		ACC_PAT_PRBS = 4'h8,
		ACC_PAT_SINE = 4'h9
	} acc_pattern_t;
endpackage : acc_pkg

// *** acc_pattern_gen.sv ***
/*
 * one channel's test pattern generator.
 * assumes the same clock as the bank; restart realigns the sequences.
 */
`timescale 1ns/100ps
`default_nettype none
`include "acc_map.svh"
module acc_pattern_gen (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic restart,
	input wire logic [3:0] select,
	input wire acc_pkg::acc_sample_t custom,
	output acc_pkg::acc_sample_t pattern
);
	import acc_pkg::*;

	acc_sample_t ramp;
	acc_sample_t lfsr;
	logic [2:0] phase;
	logic tog;

	function automatic acc_sample_t sine_point(input logic [2:0] p);
		unique case (p)
			3'h0: sine_point = 14'h0000;
			3'h1: sine_point = 14'h095f;
			3'h2: sine_point = 14'h2000;
			3'h3: sine_point = 14'h36a0;
			3'h4: sine_point = 14'h3fff;
			3'h5: sine_point = 14'h36a0;
			3'h6: sine_point = 14'h2000;
			3'h7: sine_point = 14'h095f;
		endcase
	endfunction : sine_point

	// ----------------------------------------------------------------
	// sequence state
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b || restart) begin
			ramp <= 14'h0000;
			phase <= 3'h0;
			tog <= 1'b0;
			lfsr <= `ACC_LFSR_SEED;
		end else begin
			ramp <= ramp + 14'h0001;
			phase <= phase + 3'h1;
			tog <= ~tog;
			lfsr <= {lfsr[12:0], lfsr[13] ^ lfsr[12] ^ lfsr[11] ^ lfsr[1]};
		end
	end

	// ----------------------------------------------------------------
	// pattern choice
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pattern <= 14'h0000;
		end else begin
			case (select)
				ACC_PAT_ONES: pattern <= 14'h3fff;
				ACC_PAT_TOGGLE: pattern <= tog ? ~`ACC_TOGGLE : `ACC_TOGGLE;
				ACC_PAT_RAMP: pattern <= ramp;
				ACC_PAT_CUSTOM: pattern <= custom;
				ACC_PAT_DESKEW: pattern <= `ACC_DESKEW;
				ACC_PAT_PRBS: pattern <= lfsr;
				ACC_PAT_SINE: pattern <= sine_point(phase);
				// zeros, and unused codes show zeros
				default: pattern <= 14'h0000;
			endcase
		end
	end
endmodule : acc_pattern_gen
`default_nettype wire

// *** acc_regs.sv ***
/*
 * channel control register bank with APB slave and the channel
 * digital output path it steers.
 * assumes samples and overrange flags arrive on CLK_SYS, offset binary.
 */
// Added by the designer: register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "acc_map.svh"
module acc_regs #(
	parameter logic [13:0] CUSTOM_PATTERN = 14'h0000
) (
	input wire logic CLK_SYS,
	input wire logic RST_B,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [15:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire acc_pkg::acc_sample_t CHA_SAMPLE,
	input wire acc_pkg::acc_sample_t CHB_SAMPLE,
	input wire logic [1:0] OVR_NORMAL,
	input wire logic [1:0] OVR_FAST,
	output acc_pkg::acc_sample_t CHA_DATA_OUT,
	output acc_pkg::acc_sample_t CHB_DATA_OUT,
	output logic [1:0] OVERRANGE_PINS,
	output logic CHA_DITHER_OFF,
	output logic CHB_DITHER_OFF,
	output logic [2:0] CHA_HARMONIC_MODE,
	output logic [2:0] CHB_HARMONIC_MODE
);
	import acc_pkg::*;

	// ----------------------------------------------------------------
	// control fields
	// ----------------------------------------------------------------
	logic [1:0] chan_a_dither_off;
	logic [1:0] chan_b_dither_off;
	logic [1:0] aux_a;
	logic [1:0] aux_b;
	logic chan_a_gain_on;
	logic chan_b_gain_on;
	logic test_pattern_on;
	logic soft_reset;
	logic [2:0] chan_a_harmonic_mode;
	logic [2:0] chan_b_harmonic_mode;
	logic fast_overrange_select;
	logic pattern_align;
	logic offset_binary;
	logic [3:0] chan_a_pattern_select;
	logic [3:0] chan_b_pattern_select;

	logic [10:0] idx;
	logic addr_ok;
	logic hit;
	logic wr;
	logic clr;
	acc_byte_t next_rdata;

	assign idx = PADDR[12:2];
	assign wr = PSEL && PENABLE && PREADY && PWRITE;
	// soft reset acts on the fields one cycle after the write
	assign clr = !RST_B || soft_reset;

	always_comb begin
		hit = 1'b1;
		next_rdata = `ACC_RST_BYTE;
		unique case (idx)
			`ACC_IDX_DITHER: begin
				next_rdata[`ACC_F_DITH_A] = chan_a_dither_off;
				next_rdata[`ACC_F_DITH_B] = chan_b_dither_off;
			end
			`ACC_IDX_GAIN_A: next_rdata[`ACC_F_GAIN] = chan_a_gain_on;
			`ACC_IDX_GAIN_B: next_rdata[`ACC_F_GAIN] = chan_b_gain_on;
			`ACC_IDX_PAT_RST: begin
				// reset bit is never seen set: it clears itself
				next_rdata[`ACC_F_TP_EN] = test_pattern_on;
			end
			`ACC_IDX_MODE_A: begin
				next_rdata[`ACC_F_HARM] = chan_a_harmonic_mode;
				next_rdata[`ACC_F_FAST_OVR] = fast_overrange_select;
			end
			`ACC_IDX_MODE_B: next_rdata[`ACC_F_HARM] = chan_b_harmonic_mode;
			`ACC_IDX_FORMAT: begin
				next_rdata[`ACC_F_ALIGN] = pattern_align;
				next_rdata[`ACC_F_FMT] = offset_binary;
			end
			`ACC_IDX_PSEL_A: next_rdata[`ACC_F_PSEL_A] = chan_a_pattern_select;
			`ACC_IDX_PSEL_B: next_rdata[`ACC_F_PSEL_B] = chan_b_pattern_select;
			`ACC_IDX_DAUX_A: begin
				next_rdata[`ACC_F_DAUX_HI] = aux_a[1];
				next_rdata[`ACC_F_DAUX_LO] = aux_a[0];
			end
			`ACC_IDX_DAUX_B: begin
				next_rdata[`ACC_F_DAUX_HI] = aux_b[1];
				next_rdata[`ACC_F_DAUX_LO] = aux_b[0];
			end
			default: hit = 1'b0;
		endcase
		addr_ok = hit && (PADDR[15:13] == 3'h0) && (PADDR[1:0] == 2'h0);
	end

	// ----------------------------------------------------------------
	// apb slave: one wait state, answer registered
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			PREADY <= 1'b0;
			PRDATA <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end else begin
			PREADY <= PSEL && PENABLE && !PREADY;
			if (PSEL && PENABLE && !PREADY) begin
				PRDATA <= (addr_ok && !PWRITE) ? {24'h00_0000, next_rdata} :
					32'h0000_0000;
				PSLVERR <= !addr_ok;
			end else begin
				PSLVERR <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			soft_reset <= 1'b0;
		end else begin
			soft_reset <= wr && addr_ok && idx == `ACC_IDX_PAT_RST &&
				PWDATA[`ACC_F_SRST];
		end
	end

	// ----------------------------------------------------------------
	// register fields; reserved bits are not stored
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS) begin
		if (clr) begin
			chan_a_dither_off <= 2'h0;
			chan_b_dither_off <= 2'h0;
			aux_a <= 2'h0;
			aux_b <= 2'h0;
		end else if (wr && addr_ok) begin
			if (idx == `ACC_IDX_DITHER) begin
				chan_a_dither_off <= PWDATA[`ACC_F_DITH_A];
				chan_b_dither_off <= PWDATA[`ACC_F_DITH_B];
			end
			if (idx == `ACC_IDX_DAUX_A) begin
				aux_a <= {PWDATA[`ACC_F_DAUX_HI], PWDATA[`ACC_F_DAUX_LO]};
			end
			if (idx == `ACC_IDX_DAUX_B) begin
				aux_b <= {PWDATA[`ACC_F_DAUX_HI], PWDATA[`ACC_F_DAUX_LO]};
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (clr) begin
			chan_a_gain_on <= 1'b0;
			chan_b_gain_on <= 1'b0;
			test_pattern_on <= 1'b0;
		end else if (wr && addr_ok) begin
			if (idx == `ACC_IDX_GAIN_A) begin
				chan_a_gain_on <= PWDATA[`ACC_F_GAIN];
			end
			if (idx == `ACC_IDX_GAIN_B) begin
				chan_b_gain_on <= PWDATA[`ACC_F_GAIN];
			end
			if (idx == `ACC_IDX_PAT_RST) begin
				test_pattern_on <= PWDATA[`ACC_F_TP_EN];
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (clr) begin
			chan_a_harmonic_mode <= 3'h0;
			chan_b_harmonic_mode <= 3'h0;
			fast_overrange_select <= 1'b0;
			pattern_align <= 1'b0;
			offset_binary <= 1'b0;
		end else if (wr && addr_ok) begin
			if (idx == `ACC_IDX_MODE_A) begin
				chan_a_harmonic_mode <= PWDATA[`ACC_F_HARM];
				fast_overrange_select <= PWDATA[`ACC_F_FAST_OVR];
			end
			if (idx == `ACC_IDX_MODE_B) begin
				chan_b_harmonic_mode <= PWDATA[`ACC_F_HARM];
			end
			if (idx == `ACC_IDX_FORMAT) begin
				pattern_align <= PWDATA[`ACC_F_ALIGN];
				offset_binary <= PWDATA[`ACC_F_FMT];
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (clr) begin
			chan_a_pattern_select <= 4'h0;
			chan_b_pattern_select <= 4'h0;
		end else if (wr && addr_ok) begin
			if (idx == `ACC_IDX_PSEL_A) begin
				chan_a_pattern_select <= PWDATA[`ACC_F_PSEL_A];
			end
			if (idx == `ACC_IDX_PSEL_B) begin
				chan_b_pattern_select <= PWDATA[`ACC_F_PSEL_B];
			end
		end
	end

	// ----------------------------------------------------------------
	// static control outputs
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			CHA_DITHER_OFF <= 1'b0;
			CHB_DITHER_OFF <= 1'b0;
			CHA_HARMONIC_MODE <= 3'h0;
			CHB_HARMONIC_MODE <= 3'h0;
			OVERRANGE_PINS <= 2'h0;
		end else begin
			// mixed codes keep dither on: only the full pair disables it
			CHA_DITHER_OFF <= chan_a_dither_off == `ACC_DITH_OFF &&
				aux_a == `ACC_DITH_OFF;
			CHB_DITHER_OFF <= chan_b_dither_off == `ACC_DITH_OFF &&
				aux_b == `ACC_DITH_OFF;
			// value passes as written; choosing it is software's job
			CHA_HARMONIC_MODE <= chan_a_harmonic_mode;
			CHB_HARMONIC_MODE <= chan_b_harmonic_mode;
			OVERRANGE_PINS <= fast_overrange_select ? OVR_FAST :
				OVR_NORMAL;
		end
	end

	// ----------------------------------------------------------------
	// per channel output path
	// ----------------------------------------------------------------
	acc_sample_t raw [2];
	acc_sample_t dout [2];
	logic [3:0] sel [2];
	logic [3:0] prev_sel [2];
	logic gain_on [2];
	logic prev_align;
	logic any_change;

	assign raw[0] = CHA_SAMPLE;
	assign raw[1] = CHB_SAMPLE;
	assign sel[0] = chan_a_pattern_select;
	assign sel[1] = chan_b_pattern_select;
	assign gain_on[0] = chan_a_gain_on;
	assign gain_on[1] = chan_b_gain_on;
	assign any_change = (sel[0] != prev_sel[0]) || (sel[1] != prev_sel[1]);

	always_ff @(posedge CLK_SYS) begin
		if (!RST_B) begin
			prev_align <= 1'b0;
		end else begin
			prev_align <= pattern_align;
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
			acc_sample_t pat;
			acc_sample_t sgn;
			acc_sample_t gained;
			acc_sample_t conv;
			logic restart;

			// aligned: both restart together, free: each on its own change
			assign restart = (sel[ch] != prev_sel[ch]) ||
				(pattern_align && (any_change || !prev_align));

			always_ff @(posedge CLK_SYS) begin
				if (!RST_B) begin
					prev_sel[ch] <= 4'h0;
				end else begin
					prev_sel[ch] <= sel[ch];
				end
			end

			acc_pattern_gen u_gen (
				.clk(CLK_SYS),
				.rst_b(RST_B),
				.restart(restart),
				.select(sel[ch]),
				.custom(CUSTOM_PATTERN),
				.pattern(pat)
			);

			// gain is a fixed x2 with saturation, switched on per channel
			// by its gain bit
			always_comb begin
				sgn = raw[ch] ^ `ACC_SIGN_BIT;
				if (!gain_on[ch]) begin
					gained = sgn;
				end else if (sgn[13] != sgn[12]) begin
					gained = sgn[13] ? `ACC_SIGN_BIT : `ACC_POS_MAX;
				end else begin
					gained = {sgn[12:0], 1'b0};
				end
				conv = offset_binary ? (gained ^ `ACC_SIGN_BIT) : gained;
			end

			always_ff @(posedge CLK_SYS) begin
				if (!RST_B) begin
					dout[ch] <= 14'h0000;
				end else if (test_pattern_on &&
					sel[ch] != ACC_PAT_NORMAL) begin
					dout[ch] <= pat;
				end else begin
					dout[ch] <= conv;
				end
			end
		end
	endgenerate

	assign CHA_DATA_OUT = dout[0];
	assign CHB_DATA_OUT = dout[1];
endmodule : acc_regs
`default_nettype wire

// *** acc_regs_monitor.sv ***
/*
 * acc_regs_mon: port-level assertions on the channel control bank.
 * assumes one clock, synchronous active-low reset; bound at file foot.
 */
`timescale 1ns/100ps
`default_nettype none
module acc_regs_mon (
	input wire logic CLK_SYS,
	input wire logic RST_B,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [15:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic [1:0] OVR_NORMAL,
	input wire logic [1:0] OVR_FAST,
	input wire logic [1:0] OVERRANGE_PINS,
	input wire logic CHA_DITHER_OFF,
	input wire logic CHB_DITHER_OFF,
	input wire logic [2:0] CHA_HARMONIC_MODE
);
	logic wr_mode_a;
	assign wr_mode_a = PSEL && PENABLE && PREADY && PWRITE
		&& PADDR == 16'h001c;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_B);
	// ----------------------------------------------------------
	// properties
	// ----------------------------------------------------------
	property p_rst_out;
		disable iff (1'b0)
		!RST_B |=> OVERRANGE_PINS == 2'h0 && !PREADY
			&& !CHA_DITHER_OFF && CHA_HARMONIC_MODE == 3'h0;
	endproperty
	a_rst_out: assert property (p_rst_out)
		else $error("outputs not cleared by reset");
	property p_ready_wait;
		PSEL && PENABLE && !$past(PENABLE) |-> !PREADY ##1 PREADY;
	endproperty
	a_ready_wait: assert property (p_ready_wait)
		else $error("ready not after one wait state");
	property p_ready_one;
		PREADY |=> !PREADY;
	endproperty
	a_ready_one: assert property (p_ready_one)
		else $error("ready longer than one cycle");
	property p_err_align;
		PREADY && !PWRITE && PADDR[1:0] != 2'h0 |->
			PSLVERR && PRDATA == 32'h0;
	endproperty
	a_err_align: assert property (p_err_align)
		else $error("misaligned read not refused");
	property p_err_high;
		PREADY && PADDR[15:13] != 3'h0 |-> PSLVERR;
	endproperty
	a_err_high: assert property (p_err_high)
		else $error("out of range access not refused");
	property p_rd_upper;
		PREADY && !PWRITE |-> PRDATA[31:8] == 24'h0;
	endproperty
	a_rd_upper: assert property (p_rd_upper)
		else $error("upper read bits not zero");
	// pins are one of the two flag sets of the previous cycle
	property p_ovr_src;
		$past(RST_B) |-> OVERRANGE_PINS == $past(OVR_FAST)
			|| OVERRANGE_PINS == $past(OVR_NORMAL);
	endproperty
	a_ovr_src: assert property (p_ovr_src)
		else $error("overrange pins from wrong source");
	// field lands at the write edge, the pin copy one edge later
	property p_harm;
		wr_mode_a |-> ##2 CHA_HARMONIC_MODE == $past(PWDATA[4:2], 2);
	endproperty
	a_harm: assert property (p_harm)
		else $error("harmonic mode output not updated");
	// no bus traffic for three cycles means dither outputs hold
	property p_dith_hold;
		!$past(PSEL) && !$past(PSEL, 2) && !$past(PSEL, 3) |->
			$stable({CHA_DITHER_OFF, CHB_DITHER_OFF});
	endproperty
	a_dith_hold: assert property (p_dith_hold)
		else $error("dither output changed without access");
	c_mode_wr: cover property (wr_mode_a);
	c_err: cover property (PREADY && PSLVERR);
	c_dith: cover property ($rose(CHA_DITHER_OFF));
endmodule : acc_regs_mon
bind acc_regs acc_regs_mon mon_u (.CLK_SYS, .RST_B, .PSEL, .PENABLE,
	.PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .OVR_NORMAL,
	.OVR_FAST, .OVERRANGE_PINS, .CHA_DITHER_OFF, .CHB_DITHER_OFF,
	.CHA_HARMONIC_MODE);
`default_nettype wire

// *** test_acc_regs.sv ***
/*
 * self-checking bench for acc_regs: apb tasks, directed scenarios.
 * assumes acc_pkg, acc_map.svh and the monitor compiled before it.
 */
`timescale 1ns/100ps
`default_nettype none
module test_acc_regs;
	import acc_pkg::*;
	logic CLK_SYS = 1'b0;
	logic RST_B = 1'b0;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [15:0] PADDR = 16'h0;
	logic [31:0] PWDATA = 32'h0;
	acc_sample_t CHA_SAMPLE = 14'h0;
	acc_sample_t CHB_SAMPLE = 14'h0;
	logic [1:0] OVR_NORMAL = 2'h0;
	logic [1:0] OVR_FAST = 2'h0;
	logic [31:0] PRDATA;
	logic PREADY;
	logic PSLVERR;
	acc_sample_t CHA_DATA_OUT;
	acc_sample_t CHB_DATA_OUT;
	logic [1:0] OVERRANGE_PINS;
	logic CHA_DITHER_OFF;
	logic CHB_DITHER_OFF;
	logic [2:0] CHA_HARMONIC_MODE;
	logic [2:0] CHB_HARMONIC_MODE;
	logic [31:0] rd;
	logic er;
	logic [31:0] sum;
	acc_sample_t v0;
	int n_errors = 0;
	int checks_done = 0;
	logic [15:0] regs [7] = '{16'h4, 16'hc, 16'h10, 16'h18, 16'h1c,
		16'h20, 16'h24};
	logic [7:0] msk [7] = '{8'h3c, 8'h2, 8'h2, 8'h2, 8'h1e, 8'h1c, 8'h3};
	logic [3:0] pc [5] = '{4'h1, 4'h2, 4'h5, 4'h6, 4'h0};
	acc_sample_t pv [5] = '{14'h0, 14'h3fff, 14'h1234, 14'h3aaa, 14'h100};
	logic [15:0] bad [3] = '{16'h0008, 16'h8010, 16'h0011};

	acc_regs #(.CUSTOM_PATTERN(14'h1234)) dut_u (.CLK_SYS, .RST_B, .PSEL,
		.PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
		.CHA_SAMPLE, .CHB_SAMPLE, .OVR_NORMAL, .OVR_FAST, .CHA_DATA_OUT,
		.CHB_DATA_OUT, .OVERRANGE_PINS, .CHA_DITHER_OFF, .CHB_DITHER_OFF,
		.CHA_HARMONIC_MODE, .CHB_HARMONIC_MODE);

	always #10 CLK_SYS = ~CLK_SYS;

	// ----------------------------------------------------------
	// tasks
	// ----------------------------------------------------------
	task automatic end_of_test();
		if (n_errors == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge CLK_SYS);
	endtask : tick
	// entered just after a rising edge; ends one idle edge later
	task automatic apb(input logic w, input logic [15:0] a,
		input logic [31:0] d);
		int n;
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK_SYS);
		PENABLE <= 1'b1;
		n = 0;
		do begin
			@(posedge CLK_SYS);
			n++;
		end while (PREADY !== 1'b1 && n < 16);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(posedge CLK_SYS);
		if (n >= 16) begin
			n_errors++;
			$display("ERROR %0t: no ready", $time);
			end_of_test();
		end
	endtask : apb
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rc(input logic [15:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
		chk(er, 1'b0);
	endtask : rc
	task automatic pat(input logic [3:0] c);
		wr(16'h0028, {28'h0, c});
		tick(4);
		v0 = CHA_DATA_OUT;
		tick(1);
	endtask : pat

	// ----------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------
	initial begin
		tick(3);
		RST_B <= 1'b1;
		tick(1);
		// all ones hits reserved bits; soft reset bit kept clear here
		foreach (regs[i]) begin
			rc(regs[i], 32'h0);
			wr(regs[i], (i == 3) ? 32'hfe : 32'hff);
			rc(regs[i], {24'h0, msk[i]});
		end
		CHA_SAMPLE <= 14'h2100;
		CHB_SAMPLE <= 14'h3000;
		OVR_NORMAL <= 2'h1;
		OVR_FAST <= 2'h2;
		tick(3);
		chk({CHA_DITHER_OFF, CHB_DITHER_OFF}, 2'h0);
		chk({CHA_HARMONIC_MODE, CHB_HARMONIC_MODE}, 6'h3f);
		chk(OVERRANGE_PINS, 2'h2);
		chk(CHA_DATA_OUT, 14'h2200);
		chk(CHB_DATA_OUT, 14'h3fff);
		wr(16'h10d0, 32'h28);
		wr(16'h14d0, 32'h28);
		tick(3);
		chk({CHA_DITHER_OFF, CHB_DITHER_OFF}, 2'h3);
		wr(16'h000c, 32'h0);
		wr(16'h0024, 32'h2);
		tick(3);
		chk(CHA_DATA_OUT, 14'h0100);
		chk(CHB_DATA_OUT, 14'h1fff);
		foreach (pc[i]) begin
			wr(16'h0028, {28'h0, pc[i]});
			tick(4);
			chk(CHA_DATA_OUT, pv[i]);
		end
		pat(4'h3);
		chk(CHA_DATA_OUT ^ v0, 14'h3fff);
		pat(4'h4);
		chk(14'(CHA_DATA_OUT - v0), 14'h1);
		pat(4'h8);
		chk(CHA_DATA_OUT == v0, 1'b0);
		pat(4'h9);
		// any eight consecutive sine points sum to the same total
		sum = {18'h0, v0};
		repeat (7) begin
			sum = sum + {18'h0, CHA_DATA_OUT};
			tick(1);
		end
		chk(sum, 32'd65533);
		wr(16'h0028, 32'h4);
		wr(16'h002c, 32'h40);
		tick(4);
		chk(CHA_DATA_OUT ^ CHB_DATA_OUT, 14'h0);
		// free running: restarting channel B leaves channel A alone
		wr(16'h0024, 32'h0);
		wr(16'h002c, 32'h10);
		wr(16'h002c, 32'h40);
		tick(4);
		chk(CHA_DATA_OUT == CHB_DATA_OUT, 1'b0);
		wr(16'h0018, 32'h0);
		tick(4);
		chk(CHA_DATA_OUT, 14'h0100);
		wr(16'h0018, 32'h1);
		rc(16'h001c, 32'h0);
		rc(16'h0018, 32'h0);
		rc(16'h0024, 32'h0);
		chk(OVERRANGE_PINS, 2'h1);
		chk({CHA_DITHER_OFF, CHB_DITHER_OFF}, 2'h0);
		foreach (bad[i]) begin
			wr(bad[i], 32'h2);
			chk(er, 1'b1);
			apb(1'b0, bad[i], 32'h0);
			chk(er, 1'b1);
			chk(rd, 32'h0);
		end
		rc(16'h0010, 32'h0);
		end_of_test();
	end
endmodule : test_acc_regs
`default_nettype wire
